// >>> twee_defines.vh
// Constants for the two-wire byte memory slave: timing, command codes, states.
// Assumes the includer runs on a 10 MHz core clock.
`ifndef TWEE_DEFINES_VH
`define TWEE_DEFINES_VH

// ==========================================================================
// Timing
`define TWEE_CLK_MHZ      10
`define TWEE_T_WR_US      5000
// Longest write time converted exactly to whole core cycles.
`define TWEE_T_WR_CYC     (`TWEE_T_WR_US * `TWEE_CLK_MHZ)

// ==========================================================================
// Control byte layout, most significant bit first on the wire
`define TWEE_BITS_PER_BYTE 4'h8
`define TWEE_CMD_WRITE     2'h1
`define TWEE_CMD_READ      2'h2
`define TWEE_ADDR_W        4
`define TWEE_DATA_W        8

// ==========================================================================
// Commit buffer
`define TWEE_FIFO_DEPTH    16

// ==========================================================================
// Protocol states
`define TWEE_ST_IDLE       3'h0
`define TWEE_ST_CMD        3'h1
`define TWEE_ST_WDATA      3'h2
`define TWEE_ST_WPUSH      3'h3
`define TWEE_ST_WBUSY      3'h4
`define TWEE_ST_RDATA      3'h5

`endif

// >>> twee_slave.v
// Two-wire 16 x 8 byte memory slave: pin sampling, protocol engine, array,
// commit buffer and self-timed write engine.
// Assumes the serial clock and data pins arrive asynchronously and are
// sampled by the 10 MHz core clock; the data pin is push/pull.
//
// Overview of operation
// - Data changes only while clock low; changes while clock high mark start/stop.
// - Start is data falling with clock high; nothing happens before one.
// - Start during control byte or write data restarts command reception.
// - Starts are ignored while read data is driven or the array is writing.
// - Stop is data rising with clock high; during input it returns to standby.
// - Stops are ignored while read data is driven or the array is writing.
// - Write: start, then control byte of command 0,1, four address, two spare.
// - After a write control byte, eight data bits are taken then committed.
// - While the array write runs, all pin activity is ignored.
// - Start or stop before the last write bit ends the write.
// - When the array write ends, counters clear and the device goes standby.
// - Read: start, then control byte of command 1,0, four address, two spare.
// - After a read control byte, the addressed byte is driven over eight clocks.
// - After the eighth read bit, counters clear and the device goes standby.
// - Reads abort by start or stop during command and address bits only.
// - During the second spare bit of a read, start and stop are ignored.
// - Data output drives both levels actively, never open-drain.
// - Array write lasts at most 5 ms with the data pin released.
`timescale 1ns/10ps
`include "twee_defines.vh"

// ==========================================================================
// Commit buffer
module twee_fifo #(
  parameter WIDTH = 12,
  parameter DEPTH = 16
) (
  // Clock and control
  input  wire             clk_i,
  input  wire             rst_n_i,
  input  wire             ce_i,
  // Fill side
  input  wire             in_valid_i,
  output wire             in_ready_o,
  input  wire [WIDTH-1:0] in_data_i,
  // Drain side
  output wire             out_valid_o,
  input  wire             out_ready_i,
  output wire [WIDTH-1:0] out_data_o
);
  localparam AW = (DEPTH > 1) ? $clog2(DEPTH) : 1;

  // Storage, pointers and occupancy.
  reg [WIDTH-1:0] store [0:DEPTH-1];
  reg [AW-1:0]    wr_ptr;
  reg [AW-1:0]    rd_ptr;
  reg [AW:0]      count;
  wire            do_push;
  wire            do_pop;

  // Full and empty come from the occupancy count, so they never lie.
  assign in_ready_o  = (count != DEPTH[AW:0]);
  assign out_valid_o = (count != {(AW+1){1'b0}});
  assign out_data_o  = store[rd_ptr];
  assign do_push     = in_valid_i & in_ready_o;
  assign do_pop      = out_valid_o & out_ready_i;

  // Pointers wrap explicitly so any depth works, not only powers of two.
  always @(posedge clk_i) begin
    if (!rst_n_i) begin
      wr_ptr <= {AW{1'b0}};
      rd_ptr <= {AW{1'b0}};
      count  <= {(AW+1){1'b0}};
    end else if (ce_i) begin
      if (do_push) begin
        store[wr_ptr] <= in_data_i;
        wr_ptr        <= (wr_ptr == DEPTH[AW-1:0] - 1'b1) ? {AW{1'b0}} : wr_ptr + 1'b1;
      end
      if (do_pop) begin
        rd_ptr <= (rd_ptr == DEPTH[AW-1:0] - 1'b1) ? {AW{1'b0}} : rd_ptr + 1'b1;
      end
      if (do_push && !do_pop) begin
        count <= count + 1'b1;
      end else if (do_pop && !do_push) begin
        count <= count - 1'b1;
      end
    end
  end
endmodule

// ==========================================================================
// Protocol slave
module twee_slave #(
  parameter WRITE_CYCLES = `TWEE_T_WR_CYC,
  parameter FIFO_DEPTH   = `TWEE_FIFO_DEPTH
) (
  // Clock, reset, enable
  input  wire CORE_CLK_I,
  input  wire RESETN_I,
  input  wire CE_I,
  // Serial bus pins
  input  wire SCL_I,
  input  wire SDA_I,
  output reg  SDA_O,
  output reg  SDA_OE_O,
  // Status
  output reg  WR_BUSY_O
);
  localparam AW    = `TWEE_ADDR_W;
  localparam DW    = `TWEE_DATA_W;
  localparam TMR_W = $clog2(WRITE_CYCLES + 1);
  // The engine starts two cycles after the last bit edge and needs one more
  // to retire, so it stops short to keep the whole cycle within the limit.
  // The full-width value is cut to the timer width on purpose.
  localparam [31:0]      WR_LAST_FULL = WRITE_CYCLES - 4;
  localparam [TMR_W-1:0] WR_LAST      = WR_LAST_FULL[TMR_W-1:0];

  // Filtered pin levels and their one-cycle-old copies; bit 0 clock, bit 1 data.
  wire [1:0]    pin_raw;
  wire [1:0]    pin_f;
  wire [1:0]    pin_q;
  wire          scl_f;
  wire          sda_f;
  wire          scl_q;
  wire          sda_q;
  // Protocol state, bit counter and shifters.
  reg  [2:0]    state;
  reg  [3:0]    bit_cnt;
  reg  [7:0]    shift;
  reg  [AW-1:0] addr;
  reg  [DW-1:0] rd_shift;
  // Array and self-timed write engine.
  reg  [DW-1:0] mem [0:(1<<AW)-1];
  reg           eng_run;
  reg  [TMR_W-1:0] eng_tmr;
  // Decoded bus events and commit buffer handshake.
  wire          scl_rise;
  wire          scl_fall;
  wire          start_seen;
  wire          stop_seen;
  wire          read_guard;
  wire          fifo_in_ready;
  wire          fifo_out_valid;
  wire          fifo_out_ready;
  wire [AW+DW-1:0] fifo_out_data;
  wire          wr_done;

  // ========================================================================
  // Pin sampling
  // Three flops per pin; a level is accepted only when the second and third
  // agree, which rejects a single-sample glitch at the cost of latency.
  // Both pins see the same delay, so a data change just after a clock
  // edge can never pass for a start or stop.
  assign pin_raw = {SDA_I, SCL_I};

  // One filter per pin; the filtered level resets high, the idle bus level.
  genvar g;
  generate
    for (g = 0; g < 2; g = g + 1) begin : g_pin
      reg [2:0] sync;
      reg       filt;
      reg       dly;
      // Shift in, accept a level when two samples agree, then delay once.
      always @(posedge CORE_CLK_I) begin
        if (!RESETN_I) begin
          sync <= 3'h7;
          filt <= 1'b1;
          dly  <= 1'b1;
        end else if (CE_I) begin
          sync <= {sync[1:0], pin_raw[g]};
          if (sync[1] == sync[2]) begin
            filt <= sync[2];
          end
          dly <= filt;
        end
      end
      assign pin_f[g] = filt;
      assign pin_q[g] = dly;
    end
  endgenerate

  // Named views of the filtered pins.
  assign scl_f = pin_f[0];
  assign sda_f = pin_f[1];
  assign scl_q = pin_q[0];
  assign sda_q = pin_q[1];

  // Edges and bus conditions from the filtered levels.
  assign scl_rise   = scl_f & ~scl_q;
  assign scl_fall   = ~scl_f & scl_q;
  assign start_seen = scl_f & scl_q & sda_q & ~sda_f;
  assign stop_seen  = scl_f & scl_q & ~sda_q & sda_f;

  // Last spare bit of a read control byte: seven bits in, command reads 1,0.
  // The master may let go of the line here, so its level is not trusted.
  assign read_guard = (state == `TWEE_ST_CMD) && (bit_cnt == 4'h7) &&
                      (shift[6:5] == `TWEE_CMD_READ);

  // ========================================================================
  // Protocol engine
  always @(posedge CORE_CLK_I) begin
    if (!RESETN_I) begin
      state    <= `TWEE_ST_IDLE;
      bit_cnt  <= 4'h0;
      shift    <= 8'h00;
      addr     <= {AW{1'b0}};
      rd_shift <= {DW{1'b0}};
      SDA_O    <= 1'b0;
      SDA_OE_O <= 1'b0;
    end else if (CE_I) begin
      case (state)
        `TWEE_ST_IDLE: begin
          // Counters stay clear in standby so every command starts at bit zero.
          bit_cnt <= 4'h0;
          if (start_seen) begin
            state <= `TWEE_ST_CMD;
          end
        end
        `TWEE_ST_CMD: begin
          // A start restarts the control byte and a stop drops to standby;
          // both are refused once seven bits of a read control byte are in.
          if (start_seen && !read_guard) begin
            bit_cnt <= 4'h0;
          end else if (stop_seen && !read_guard) begin
            state   <= `TWEE_ST_IDLE;
            bit_cnt <= 4'h0;
          end else if (scl_rise) begin
            shift   <= {shift[6:0], sda_f};
            bit_cnt <= bit_cnt + 4'h1;
            if (bit_cnt == `TWEE_BITS_PER_BYTE - 4'h1) begin
              bit_cnt <= 4'h0;
              addr    <= shift[4:1];
              if (shift[6:5] == `TWEE_CMD_WRITE) begin
                state <= `TWEE_ST_WDATA;
              end else if (shift[6:5] == `TWEE_CMD_READ) begin
                rd_shift <= mem[shift[4:1]];
                state    <= `TWEE_ST_RDATA;
              end else begin
                state <= `TWEE_ST_IDLE;
              end
            end
          end
        end
        `TWEE_ST_WDATA: begin
          // Either condition before the last data bit abandons the write.
          if (start_seen) begin
            state   <= `TWEE_ST_CMD;
            bit_cnt <= 4'h0;
          end else if (stop_seen) begin
            state   <= `TWEE_ST_IDLE;
            bit_cnt <= 4'h0;
          end else if (scl_rise) begin
            shift   <= {shift[6:0], sda_f};
            bit_cnt <= bit_cnt + 4'h1;
            if (bit_cnt == `TWEE_BITS_PER_BYTE - 4'h1) begin
              bit_cnt <= 4'h0;
              state   <= `TWEE_ST_WPUSH;
            end
          end
        end
        `TWEE_ST_WPUSH: begin
          // Waits here if the commit buffer is full; the bus stays deaf.
          if (fifo_in_ready) begin
            state <= `TWEE_ST_WBUSY;
          end
        end
        `TWEE_ST_WBUSY: begin
          // Pins are not looked at until the array write retires.
          if (wr_done) begin
            state   <= `TWEE_ST_IDLE;
            bit_cnt <= 4'h0;
          end
        end
        `TWEE_ST_RDATA: begin
          // Start and stop are not checked: the bus belongs to us here.
          if (scl_fall) begin
            if (bit_cnt == `TWEE_BITS_PER_BYTE) begin
              SDA_OE_O <= 1'b0;
              bit_cnt  <= 4'h0;
              state    <= `TWEE_ST_IDLE;
            end else begin
              SDA_O    <= rd_shift[DW-1];
              SDA_OE_O <= 1'b1;
              rd_shift <= {rd_shift[DW-2:0], 1'b0};
              bit_cnt  <= bit_cnt + 4'h1;
            end
          end
        end
        default: begin
          state    <= `TWEE_ST_IDLE;
          bit_cnt  <= 4'h0;
          SDA_OE_O <= 1'b0;
        end
      endcase
    end
  end

  // ========================================================================
  // Commit buffer between the receive shifter and the array
  // Writes queue here, yet the bus logic still waits in WBUSY for wr_done, so the array timing reaches back into it.
  twee_fifo #(
    .WIDTH (AW + DW),
    .DEPTH (FIFO_DEPTH)
  ) u_commit (
    .clk_i       (CORE_CLK_I),
    .rst_n_i     (RESETN_I),
    .ce_i        (CE_I),
    .in_valid_i  (state == `TWEE_ST_WPUSH),
    .in_ready_o  (fifo_in_ready),
    .in_data_i   ({addr, shift}),
    .out_valid_o (fifo_out_valid),
    .out_ready_i (fifo_out_ready),
    .out_data_o  (fifo_out_data)
  );

  // The engine only drains once its timer has run out, so the buffer truly
  // back-pressures the protocol engine if entries ever pile up.
  assign fifo_out_ready = eng_run && (eng_tmr == WR_LAST);
  assign wr_done        = fifo_out_ready;

  // ========================================================================
  // Self-timed array write
  always @(posedge CORE_CLK_I) begin
    if (!RESETN_I) begin
      eng_run   <= 1'b0;
      eng_tmr   <= {TMR_W{1'b0}};
      WR_BUSY_O <= 1'b0;
    end else if (CE_I) begin
      // Busy follows the protocol state, so it also covers a wait for buffer space.
      WR_BUSY_O <= (state == `TWEE_ST_WPUSH) || (state == `TWEE_ST_WBUSY);
      if (!eng_run) begin
        if (fifo_out_valid) begin
          eng_run <= 1'b1;
          eng_tmr <= {TMR_W{1'b0}};
        end
      end else if (eng_tmr == WR_LAST) begin
        mem[fifo_out_data[AW+DW-1:DW]] <= fifo_out_data[DW-1:0];
        eng_run <= 1'b0;
      end else begin
        eng_tmr <= eng_tmr + 1'b1;
      end
    end
  end
endmodule

// >>> twee_master.sv
// Bus master model that drives the serial clock and data of the byte memory slave.
// Assumes its tasks are entered on a falling edge of a 100 ns core clock.
`timescale 1ns/10ps
// =====
// Master with an 800 ns serial clock.
module twee_master (
  // Serial pins
  output reg  scl_o,
  output reg  sda_o,
  output reg  oe_o,
  input  wire sda_i
);
  integer i;
  // The bus idles with both lines high and the clock standing still.
  initial begin
    scl_o = 1'b1;
    sda_o = 1'b1;
    oe_o  = 1'b1;
  end
  // One clock: data moves while the clock is low; flip makes a start or stop.
  task clk(input b, input flip);
    begin
      scl_o = 1'b0;
      #200 sda_o = b;
      oe_o = 1'b1;
      #200 scl_o = 1'b1;
      #200 if (flip) sda_o = ~b;
      #200;
    end
  endtask
  // Byte out, most significant bit first.
  task wbyte(input [7:0] v);
    for (i = 7; i >= 0; i = i - 1) clk(v[i], 1'b0);
  endtask
  // Byte write: start, control byte, data byte.
  task wr(input [3:0] a, input [7:0] d);
    begin
      clk(1'b1, 1'b1);
      wbyte({2'b01, a, 2'b00});
      wbyte(d);
    end
  endtask
  // Byte read; the line is freed during the last spare bit so the slave can drive it.
  task rbyte(input [3:0] a, output [7:0] v);
    reg [7:0] c;
    begin
      c = {2'b10, a, 2'b00};
      clk(1'b1, 1'b1);
      for (i = 7; i >= 1; i = i - 1) clk(c[i], 1'b0);
      scl_o = 1'b0;
      #200 sda_o = 1'b0;
      #200 scl_o = 1'b1;
      #200 oe_o = 1'b0;
      #200;
      for (i = 7; i >= 0; i = i - 1) begin
        scl_o = 1'b0;
        #400 scl_o = 1'b1;
        #400 v[i] = sda_i;
      end
      scl_o = 1'b0;
      #600 oe_o = 1'b1;
      sda_o = 1'b1;
      #200 scl_o = 1'b1;
      #400;
    end
  endtask
endmodule

// >>> twee_slave_props.sv
// Concurrent checks on the ports of the byte memory slave.
// Assumes one core clock domain with a synchronous active-low reset.
`timescale 1ns/10ps
// =====
// Checker bound to every slave instance.
module twee_slave_props #(
  parameter WRITE_CYCLES = 50000
) (
  input logic CORE_CLK_I,
  input logic RESETN_I,
  input logic CE_I,
  input logic SCL_I,
  input logic SDA_I,
  input logic SDA_O,
  input logic SDA_OE_O,
  input logic WR_BUSY_O
);
  integer busy_cnt;
  integer fall_cnt;
  logic   scl_q;
  default clocking dc @(posedge CORE_CLK_I); endclocking
  default disable iff (!RESETN_I);
  // Busy length and pin clock falls while driving, so lengths can be bounded.
  // Busy counts enabled cycles only: a frozen block does not advance its timer.
  always @(posedge CORE_CLK_I) begin
    scl_q    <= SCL_I;
    busy_cnt <= (!RESETN_I || !WR_BUSY_O) ? 0 : busy_cnt + (CE_I ? 1 : 0);
    fall_cnt <= (!RESETN_I || !SDA_OE_O) ? 0 : fall_cnt + (scl_q & !SCL_I);
  end
  sequence s_quiet_gap;
    !WR_BUSY_O [*8];
  endsequence
  a_busy_no_drive: assert property (WR_BUSY_O |-> !SDA_OE_O)
    else $error("data driven during array write");
  a_busy_limit: assert property (busy_cnt <= WRITE_CYCLES)
    else $error("array write too long");
  a_busy_length: assert property ($fell(WR_BUSY_O) |-> busy_cnt >= WRITE_CYCLES - 2)
    else $error("array write too short");
  a_busy_gap: assert property ($fell(WR_BUSY_O) |-> s_quiet_gap)
    else $error("busy again without a new command");
  a_drive_on_low: assert property (($rose(SDA_OE_O) || (SDA_OE_O && $changed(SDA_O)))
    |-> !$past(SCL_I, 3)) else $error("read data moved outside clock low");
  a_read_eight: assert property ($fell(SDA_OE_O) |-> fall_cnt == 8)
    else $error("read drive not eight bits");
  a_ce_freeze: assert property (!CE_I |=> $stable(SDA_O) && $stable(SDA_OE_O) && $stable(WR_BUSY_O))
    else $error("state moved with enable low");
  a_reset_clears: assert property (disable iff (1'b0) (!RESETN_I && CE_I) |=> !SDA_OE_O && !WR_BUSY_O)
    else $error("reset left outputs active");
endmodule

bind twee_slave twee_slave_props #(.WRITE_CYCLES(WRITE_CYCLES)) u_props (
  .CORE_CLK_I(CORE_CLK_I), .RESETN_I(RESETN_I), .CE_I(CE_I), .SCL_I(SCL_I), .SDA_I(SDA_I),
  .SDA_O(SDA_O), .SDA_OE_O(SDA_OE_O), .WR_BUSY_O(WR_BUSY_O));

// >>> test_two_wire_byte_eeprom_slave.sv
// Self-checking bench for the byte memory slave with a master model on the bus.
// Assumes a short write time parameter so that self-timed writes retire quickly.
`timescale 1ns/10ps
// =====
// Bench top.
module test_two_wire_byte_eeprom_slave;
  localparam WR_CYC = 40;
  localparam LIMIT  = 20000;
  reg        clk;
  reg        rst_n;
  reg        ce;
  reg        sda_last;
  reg        seen;
  reg  [7:0] rd;
  reg  [3:0] a;
  wire       scl;
  wire       m_sda;
  wire       m_oe;
  wire       sda_o;
  wire       sda_oe;
  wire       wr_busy;
  wire       sda_w;
  integer    n_fail;
  integer    tests_run;
  integer    cycles;
  integer    k;
  integer    j;
  // Push/pull wire; undriven it toggles every cycle so a stale level never passes.
  assign sda_w = sda_oe ? sda_o : (m_oe ? m_sda : ~sda_last);
  always #50 clk = ~clk;
  always @(negedge clk) sda_last <= sda_w;
  twee_master u_m (.scl_o(scl), .sda_o(m_sda), .oe_o(m_oe), .sda_i(sda_w));
  twee_slave #(.WRITE_CYCLES(WR_CYC)) u_dut (
    .CORE_CLK_I(clk), .RESETN_I(rst_n), .CE_I(ce), .SCL_I(scl), .SDA_I(sda_w),
    .SDA_O(sda_o), .SDA_OE_O(sda_oe), .WR_BUSY_O(wr_busy));
  task check(input [7:0] s, input [7:0] e);
    begin
      tests_run = tests_run + 1;
      if (s !== e) begin
        n_fail = n_fail + 1;
        $display("CHECK FAILED at %0t: seen %h expected %h", $time, s, e);
      end
    end
  endtask
  task finish_test;
    begin
      $display("Checks %0d, mismatches %0d", tests_run, n_fail);
      if (n_fail == 0 && tests_run > 0) $display("ALL TESTS PASSED");
      else $display("TESTS FAILED");
      $finish;
    end
  endtask
  // Write must start busy promptly and retire within five cycles past the write time.
  task wait_write;
    begin
      seen = 1'b0;
      for (k = 0; k < 20 && !seen; k = k + 1) begin
        @(negedge clk);
        seen = (wr_busy === 1'b1);
      end
      check({7'h00, seen}, 8'h01);
      for (k = 0; k < WR_CYC + 5 && wr_busy !== 1'b0; k = k + 1) @(negedge clk);
      check({7'h00, wr_busy}, 8'h00);
    end
  endtask
  task idle_check;
    begin
      repeat (20) @(negedge clk);
      check({7'h00, wr_busy}, 8'h00);
    end
  endtask
  task rd_chk(input [3:0] ad, input [7:0] e);
    begin
      u_m.rbyte(ad, rd);
      check(rd, e);
    end
  endtask
  // Addresses 0, 5, 10 and 15 written, then read back to back.
  task t_write_read;
    begin
      for (j = 0; j < 4; j = j + 1) begin
        a = j * 5;
        u_m.wr(a, 8'h5a ^ {a, a});
        wait_write;
      end
      for (j = 0; j < 4; j = j + 1) begin
        a = j * 5;
        rd_chk(a, 8'h5a ^ {a, a});
      end
    end
  endtask
  // Start in mid control byte, and start or stop in mid data, ends the command.
  task t_abort;
    begin
      u_m.clk(1'b1, 1'b1);
      u_m.clk(1'b0, 1'b0);
      u_m.clk(1'b1, 1'b0);
      u_m.wr(4'h3, 8'hc3);
      wait_write;
      rd_chk(4'h3, 8'hc3);
      u_m.clk(1'b1, 1'b1);
      u_m.wbyte(8'h4c);
      for (j = 0; j < 4; j = j + 1) u_m.clk(1'b1, 1'b0);
      u_m.clk(1'b0, 1'b1);
      idle_check;
      rd_chk(4'h3, 8'hc3);
      u_m.clk(1'b1, 1'b1);
      u_m.wbyte(8'h4c);
      for (j = 0; j < 4; j = j + 1) u_m.clk(1'b0, 1'b0);
      u_m.wr(4'h3, 8'h96);
      wait_write;
      rd_chk(4'h3, 8'h96);
    end
  endtask
  // Unknown commands, bits without a start and a stopped read all leave memory alone.
  task t_ignore;
    begin
      for (j = 0; j < 2; j = j + 1) begin
        u_m.clk(1'b1, 1'b1);
        u_m.wbyte({{2{j[0]}}, 6'h0c});
        u_m.wbyte(8'hff);
        idle_check;
      end
      u_m.wbyte(8'h4c);
      u_m.wbyte(8'h00);
      idle_check;
      u_m.clk(1'b1, 1'b1);
      u_m.clk(1'b1, 1'b0);
      u_m.clk(1'b0, 1'b0);
      u_m.clk(1'b0, 1'b1);
      rd_chk(4'h3, 8'h96);
    end
  endtask
  // A second write issued during the array write must be ignored.
  task t_deaf;
    begin
      u_m.wr(4'h5, 8'h11);
      u_m.wr(4'h5, 8'h22);
      idle_check;
      rd_chk(4'h5, 8'h11);
    end
  endtask
  // Enable low in mid write holds the array timer; the write lands once it is back.
  task t_freeze;
    begin
      u_m.wr(4'h6, 8'h3c);
      for (k = 0; k < 20 && wr_busy !== 1'b1; k = k + 1) @(negedge clk);
      ce = 1'b0;
      repeat (WR_CYC + 20) @(negedge clk);
      check({7'h00, wr_busy}, 8'h01);
      ce = 1'b1;
      wait_write;
      rd_chk(4'h6, 8'h3c);
    end
  endtask
  // Reset in mid write drops busy at once; address 0 still reads its earlier value.
  task t_reset;
    begin
      u_m.wr(4'h6, 8'h81);
      for (k = 0; k < 20 && wr_busy !== 1'b1; k = k + 1) @(negedge clk);
      rst_n = 1'b0;
      repeat (2) @(negedge clk);
      rst_n = 1'b1;
      check({7'h00, wr_busy}, 8'h00);
      repeat (4) @(negedge clk);
      rd_chk(4'h0, 8'h5a);
    end
  endtask
  // Main sequence: reset, a frozen spell with enable low, then the scenarios.
  initial begin
    clk = 1'b0;
    rst_n = 1'b0;
    ce = 1'b1;
    n_fail = 0;
    tests_run = 0;
    cycles = 0;
    repeat (16) @(negedge clk);
    rst_n = 1'b1;
    ce = 1'b0;
    repeat (8) @(negedge clk);
    ce = 1'b1;
    repeat (4) @(negedge clk);
    t_write_read;
    t_abort;
    t_ignore;
    t_deaf;
    t_freeze;
    t_reset;
    finish_test;
  end
  // Hang guard well above the expected run length.
  always @(negedge clk) begin
    cycles = cycles + 1;
    if (cycles == LIMIT) begin
      n_fail = n_fail + 1;
      finish_test;
    end
  end
endmodule
